// ### design/acs_top.sv
// Conversion sequencer: registers, sequence control and result slots
// Operation
// - mode is continuous, multi, eight bits
// - mode 0: four on one channel, stop
// - mode 1: eight on one channel, stop
// - mode 2: four channel block once
// - mode 3: eight channel block once
// - mode 4: four on one, repeating
// - mode 5: eight on one, repeating
// - mode 6: four channel block, repeating
// - mode 7: eight channel block, repeating
// - repeats overwrite earlier slot contents
// - slot flag set when slot written
// - single modes flag sequence end
// - continuous flags first pass end
// - channel field codes select inputs
// - continuous bit sets pass repetition
// - ascending channels into ascending slots
// - control write starts new sequence
// - control writes abort, clear flags
// - timing write aborts and halts
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module acs_top
    import acs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Multiplexer and approximation array
    output logic [CHAN_W-1:0] mux_chan,
    output logic mux_ref_sel,
    output logic conv_start,
    output logic conv_abort,
    input wire logic conv_done,
    input wire logic [RES_W-1:0] conv_result,
    // Sequence state for the chip
    output logic seq_busy
);
    acs_seq_if sq ();

    logic [DATA_W-1:0] timing_control_reg;  // Stored, steers nothing here
    logic [CTL_W-1:0] conversion_control_reg;
    logic [RES_W-1:0] result_slot_reg [SLOTS];
    acs_state_t state_reg;
    acs_state_t state_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [CHAN_W-1:0] chan_reg;
    logic start_reg;
    logic abort_reg;
    logic busy_reg;   // Sequencer not idle
    logic ref_reg;    // Channel code is an internal reference
    logic wr_timing;  // Timing register written
    logic wr_conv;    // Conversion register written
    logic take;       // Result accepted this cycle
    logic [2:0] mode; // Conversion mode number

    // Address decode of the writes
    assign wr_timing = reg_wr && (reg_addr == OFF_TIMING);
    assign wr_conv = reg_wr && (reg_addr == OFF_CONV);

    // Mode number: continuous is the top bit, eight the bottom
    assign mode = {conversion_control_reg[CONV_CONT_BIT],
                   conversion_control_reg[CONV_MULTI_BIT],
                   conversion_control_reg[CONV_EIGHT_BIT]};

    // A result counts only while waiting and not aborted that cycle
    assign take = (state_reg == ST_WAIT) && conv_done && !sq.clear;

    // Carrier drive
    assign sq.restart = wr_conv;
    assign sq.clear = wr_conv || wr_timing;
    assign sq.advance = take;
    assign sq.cont = mode[2];
    assign sq.multi = mode[1];
    assign sq.eight = mode[0];
    assign sq.chan_field = conversion_control_reg[CONV_CHAN_LSB +: CHAN_W];

    acs_step u_step (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .sq(sq)
    );

    acs_flags u_flags (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .sq(sq)
    );

    // Outputs
    assign reg_rdata = rdata_reg;
    assign mux_chan = chan_reg;
    assign mux_ref_sel = ref_reg;
    assign conv_start = start_reg;
    assign conv_abort = abort_reg;
    assign seq_busy = busy_reg;

    // Timing register; its write halts the sequencer
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            timing_control_reg <= TIMING_RST;
        end else if (wr_timing) begin
            timing_control_reg <= reg_wdata;
        end
    end

    // Conversion control register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            conversion_control_reg <= CONV_RST;
        end else if (wr_conv) begin
            conversion_control_reg <= reg_wdata[CTL_W-1:0];
        end
    end

    // Sequence control; a write wins over a result arriving that cycle
    always_comb begin
        state_next = state_reg;
        if (wr_conv) begin
            state_next = ST_START;
        end else if (wr_timing) begin
            state_next = ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    state_next = ST_IDLE;
                end
                ST_START: begin
                    state_next = ST_WAIT;
                end
                ST_WAIT: begin
                    if (take && sq.last && !sq.cont) begin
                        state_next = ST_IDLE;
                    end else if (take) begin
                        state_next = ST_START;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Busy from a flop so the status bit and pin carry no decode glitch
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (state_next != ST_IDLE);
        end
    end

    // Channel and start strobe; both registered, so the channel changes on the edge that raises start
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            chan_reg <= 4'h0;
            ref_reg <= 1'b0;
            start_reg <= 1'b0;
        end else begin
            chan_reg <= sq.chan;
            ref_reg <= (sq.chan >= CH_REF_HIGH);
            start_reg <= (state_reg == ST_START) && !sq.clear;
        end
    end

    // Abort pulse tells the array to drop a conversion in flight
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            abort_reg <= 1'b0;
        end else begin
            abort_reg <= sq.clear && (state_reg != ST_IDLE);
        end
    end

    // Result slots; repeats simply overwrite
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < SLOTS; i++) begin
                result_slot_reg[i] <= RESULT_RST;
            end
        end else if (take) begin
            result_slot_reg[sq.idx] <= conv_result;
        end
    end

    // Read decode; unmapped offsets read zero
    always_comb begin
        rdata_next = 16'h0000;
        if (reg_addr[3]) begin
            rdata_next[RES_W-1:0] = result_slot_reg[reg_addr[2:0]];
        end else if (reg_addr == OFF_TIMING) begin
            rdata_next = timing_control_reg;
        end else if (reg_addr == OFF_CONV) begin
            rdata_next[CTL_W-1:0] = conversion_control_reg;
        end else if (reg_addr == OFF_STATUS) begin
            rdata_next[STAT_CCF_LSB +: SLOTS] = sq.ccf;
            rdata_next[STAT_SCF_BIT] = sq.seq_complete_flag;
            rdata_next[STAT_SLOT_LSB +: SLOT_W] = sq.idx;
            rdata_next[STAT_BUSY_BIT] = seq_busy;
        end
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= reg_rd ? rdata_next : 16'h0000;
        end
    end

    // Checks; all are off while reset is held
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    mode_load_a: assert property (wr_conv |=> mode == {$past(reg_wdata[6]),
        $past(reg_wdata[5]), $past(reg_wdata[4])})
        else $error("mode not loaded from control write");
    slot_flag_a: assert property (take |=> sq.ccf[$past(sq.idx)])
        else $error("slot flag not set on result");
    slot_data_a: assert property (take |=>
        result_slot_reg[$past(sq.idx)] == $past(conv_result))
        else $error("result not stored in its slot");
    single_stop_a: assert property (take && sq.last && !sq.cont
        |=> state_reg == ST_IDLE && sq.seq_complete_flag && sq.idx == 3'h0)
        else $error("single sequence did not stop flagged");
    cont_wrap_a: assert property (take && sq.last && sq.cont
        |=> state_reg == ST_START && sq.seq_complete_flag && sq.idx == 3'h0
        ##1 (conv_start || $past(sq.clear)))
        else $error("continuous pass did not wrap");
    // Stepping keeps the pass flag; an abort only rewinds on restart
    slot_step_a: assert property (take && !sq.last
        |=> sq.idx == 3'($past(sq.idx) + 3'h1) && sq.seq_complete_flag == $past(sq.seq_complete_flag))
        else $error("slot index did not advance");
    abort_clr_a: assert property (sq.clear
        |=> sq.ccf == 8'h00 && !sq.seq_complete_flag
        && sq.idx == ($past(wr_conv) ? 3'h0 : $past(sq.idx)))
        else $error("abort left flags set");
    halt_a: assert property (wr_timing && !wr_conv
        |=> state_reg == ST_IDLE ##1 !conv_start)
        else $error("timing write did not halt");
    restart_a: assert property (wr_conv
        |=> state_reg == ST_START && sq.idx == 3'h0
        ##1 (conv_start || $past(sq.clear)))
        else $error("control write did not start a sequence");
    block_chan_a: assert property (conv_start && mode[1] && !mode[0]
        |-> mux_chan == {conversion_control_reg[3:2], sq.idx[1:0]})
        else $error("block channel wrong");
    one_chan_a: assert property (conv_start && !mode[1]
        |-> mux_chan == conversion_control_reg[3:0])
        else $error("single channel wrong");
    // Eight channel block per slot, and the reference flag
    eight_chan_a: assert property (conv_start && mode[1] && mode[0]
        |-> mux_chan == {conversion_control_reg[3], sq.idx})
        else $error("eight channel block wrong");
    ref_sel_a: assert property (mux_ref_sel
        == (mux_chan[3:2] == 2'b11))
        else $error("reference select wrong");
    // Aborts, stray results and halting
    abort_pulse_a: assert property (sq.clear && state_reg != ST_IDLE
        |=> conv_abort)
        else $error("abort pulse missing");
    done_ignored_a: assert property (conv_done && state_reg != ST_WAIT
        && !sq.clear
        |=> sq.ccf == $past(sq.ccf) && sq.idx == $past(sq.idx))
        else $error("result taken outside wait");
    idle_hold_a: assert property (state_reg == ST_IDLE && !wr_conv
        |=> state_reg == ST_IDLE)
        else $error("halted sequencer restarted itself");
    // Pass length: slot three or slot seven ends it
    four_len_a: assert property (take && !mode[0] |-> sq.idx <= 3'h3)
        else $error("four pass ran past slot three");
    eight_len_a: assert property (take && sq.idx == 3'h7
        |=> sq.idx == 3'h0)
        else $error("eight pass did not wrap");

    // Main scenarios reached
    mode0_done_c: cover property (mode == 3'h0 && take && sq.last);
    mode2_block_c: cover property (mode == 3'h2 && take && sq.last);
    halt_run_c: cover property (state_reg == ST_WAIT && wr_timing);
    mode7_wrap_c: cover property (mode == 3'h7 && take && sq.last
        ##1 state_reg == ST_START);
    abort_run_c: cover property (state_reg == ST_WAIT && wr_conv);
endmodule : acs_top

// ### design/acs_pkg.sv
// Shared constants, field layout and state codes of the conversion sequencer
package acs_pkg;
    // Bus widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int RES_W = 10;
    localparam int SLOTS = 8;
    localparam int SLOT_W = 3;
    localparam int CHAN_W = 4;
    localparam int CTL_W = 7;

    // Register offsets (word index on the register port)
    localparam logic [3:0] OFF_TIMING = 4'h0;
    localparam logic [3:0] OFF_CONV = 4'h1;
    localparam logic [3:0] OFF_STATUS = 4'h2;
    localparam logic [3:0] OFF_RESULT = 4'h8;

    // Conversion control field positions
    localparam int CONV_CHAN_LSB = 0;
    localparam int CONV_EIGHT_BIT = 4;
    localparam int CONV_MULTI_BIT = 5;
    localparam int CONV_CONT_BIT = 6;

    // Status field positions
    localparam int STAT_CCF_LSB = 0;
    localparam int STAT_SCF_BIT = 8;
    localparam int STAT_SLOT_LSB = 9;
    localparam int STAT_BUSY_BIT = 15;

    // Values after reset
    localparam logic [15:0] TIMING_RST = 16'h0000;
    localparam logic [6:0] CONV_RST = 7'h00;
    localparam logic [9:0] RESULT_RST = 10'h000;
    localparam logic [7:0] CCF_RST = 8'h00;

    // Last slot index of a four or eight conversion pass
    localparam logic [2:0] LEN4_LAST = 3'h3;
    localparam logic [2:0] LEN8_LAST = 3'h7;

    // First internal reference code of the channel field
    localparam logic [3:0] CH_REF_HIGH = 4'hC;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_WAIT = 2'b10
    } acs_state_t;
endpackage : acs_pkg

// ### design/acs_seq_if.sv
// Carrier between the sequencer control, slot stepper and flag logic
`timescale 1ns/100ps
interface acs_seq_if;
    logic restart;      // New sequence begins
    logic advance;      // One conversion taken
    logic clear;        // Abort: drop flags
    logic eight;        // Eight conversions per pass
    logic multi;        // Block of channels
    logic cont;         // Continuous operation
    logic [3:0] chan_field;
    logic [2:0] idx;    // Current result slot
    logic last;         // Current slot ends the pass
    logic [3:0] chan;   // Channel for current slot
    logic [7:0] ccf;    // Per-slot complete flags
    logic seq_complete_flag;          // Sequence complete flag

    modport ctrl (output restart, advance, clear, eight, multi, cont,
                  chan_field, input idx, last, chan, ccf, seq_complete_flag);
    modport step (input restart, advance, eight, multi, chan_field,
                  output idx, last, chan);
    modport flags (input clear, advance, idx, last, output ccf, seq_complete_flag);
endinterface : acs_seq_if

// ### design/acs_step.sv
// Slot index counter and channel selection of the conversion sequencer
`timescale 1ns/100ps
module acs_step
    import acs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Sequencer carrier
    acs_seq_if.step sq
);
    logic [2:0] idx_reg;  // Slot of the running conversion
    logic [2:0] idx_next;

    // Channel for a slot; a block is aligned on the field's upper bits
    function automatic logic [3:0] acs_chan_sel(input logic multi,
            input logic eight, input logic [3:0] field,
            input logic [2:0] idx);
        logic [3:0] ch;
        ch = field;
        if (multi && eight) begin
            ch = {field[3], idx};
        end else if (multi) begin
            ch = {field[3:2], idx[1:0]};
        end
        return ch;
    endfunction : acs_chan_sel

    // Pass ends at slot three or slot seven
    assign sq.last = (idx_reg == (sq.eight ? LEN8_LAST : LEN4_LAST));
    assign sq.idx = idx_reg;
    assign sq.chan = acs_chan_sel(sq.multi, sq.eight, sq.chan_field,
                                  idx_reg);

    // Next slot: wrap at pass end so continuous runs reuse the slots
    always_comb begin
        idx_next = idx_reg;
        if (sq.restart) begin
            idx_next = 3'h0;
        end else if (sq.advance) begin
            idx_next = sq.last ? 3'h0 : 3'(idx_reg + 3'h1);
        end
    end

    // Slot counter
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            idx_reg <= 3'h0;
        end else begin
            idx_reg <= idx_next;
        end
    end
endmodule : acs_step

// ### design/acs_flags.sv
// Conversion-complete and sequence-complete flags
`timescale 1ns/100ps
module acs_flags
    import acs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Sequencer carrier
    acs_seq_if.flags sq
);
    logic [7:0] ccf_reg;  // One flag per result slot
    logic scf_reg;        // Sequence complete

    assign sq.ccf = ccf_reg;
    assign sq.seq_complete_flag = scf_reg;

    // Slot flag set as its slot is filled; abort clears all
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ccf_reg <= CCF_RST;
        end else if (sq.clear) begin
            ccf_reg <= CCF_RST;
        end else if (sq.advance) begin
            ccf_reg[sq.idx] <= 1'b1;
        end
    end

    // Set at first pass end; stays set while continuous runs go on
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            scf_reg <= 1'b0;
        end else if (sq.clear) begin
            scf_reg <= 1'b0;
        end else if (sq.advance && sq.last) begin
            scf_reg <= 1'b1;
        end
    end
endmodule : acs_flags

// ### dv/acs_array_model.sv
// Behavioural multiplexer and approximation array facing the sequencer
`timescale 1ns/100ps
module acs_array_model
    import acs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // From the sequencer
    input wire logic [CHAN_W-1:0] mux_chan,
    input wire logic conv_start,
    input wire logic conv_abort,
    // Bench knobs
    input wire logic slow,
    input wire logic [5:0] tag,
    // To the sequencer
    output logic conv_done,
    output logic [RES_W-1:0] conv_result
);
    logic busy_reg; // Conversion in flight
    logic [2:0] cnt_reg; // Cycles left to done
    logic [CHAN_W-1:0] chan_reg; // Channel taken at start

    // One done per start, never in the start cycle; abort drops it
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            busy_reg <= 1'b0;
            cnt_reg <= 3'h0;
            chan_reg <= 4'h0;
            conv_done <= 1'b0;
            conv_result <= 10'h000;
        end else begin
            conv_done <= 1'b0;
            // Result has no meaning outside done: keep it moving
            conv_result <= ~conv_result;
            if (conv_abort) begin
                busy_reg <= 1'b0;
            end else if (conv_start) begin
                busy_reg <= 1'b1;
                cnt_reg <= slow ? 3'h5 : 3'h1;
                chan_reg <= mux_chan;
            end else if (busy_reg) begin
                if (cnt_reg == 3'h1) begin
                    // Result tags the channel so slots can be traced
                    busy_reg <= 1'b0;
                    conv_done <= 1'b1;
                    conv_result <= {tag, chan_reg};
                end else begin
                    cnt_reg <= cnt_reg - 3'h1;
                end
            end
        end
    end
endmodule : acs_array_model

// ### dv/tb_top.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/100ps
module tb_top;
    import acs_pkg::*;
    logic ref_clk, nrst, reg_wr, reg_rd, conv_start, conv_abort;
    logic conv_done, seq_busy, mux_ref_sel, slow;
    logic [ADDR_W-1:0] reg_addr; // Register word index
    logic [DATA_W-1:0] reg_wdata, reg_rdata, v;
    logic [CHAN_W-1:0] mux_chan, f;
    logic [RES_W-1:0] conv_result;
    logic [5:0] tag; // Result marker of the array model
    int fails, checked, m, n;

    acs_top u_acs_top(.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mux_chan(mux_chan),
        .mux_ref_sel(mux_ref_sel), .conv_start(conv_start),
        .conv_abort(conv_abort), .conv_done(conv_done),
        .conv_result(conv_result), .seq_busy(seq_busy));
    acs_array_model u_acs_array_model(.ref_clk(ref_clk), .nrst(nrst),
        .mux_chan(mux_chan), .conv_start(conv_start),
        .conv_abort(conv_abort), .slow(slow), .tag(tag),
        .conv_done(conv_done), .conv_result(conv_result));

    // 20 MHz clock
    always #25 ref_clk = ~ref_clk;

    // Reference flag against the channel code while a start stands
    always @(negedge ref_clk) begin
        if (conv_start === 1'b1) begin
            check("mux_ref_sel", {15'h0000, mux_ref_sel},
                  {15'h0000, mux_chan[3:2] == 2'b11});
        end
    end

    // Verdict and end of run
    task report_and_stop;
        if (fails == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop

    // Compare one value, four-state exact
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // One-cycle read strobe; data only in the following cycle
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // Bounded wait for a number of done pulses
    task automatic wait_dones(input int cnt);
        int k, got;
        got = 0;
        for (k = 0; k < 400 && got < cnt; k++) begin
            @(posedge ref_clk);
            if (conv_done === 1'b1) got++;
        end
        if (got < cnt) begin
            fails++;
            report_and_stop();
        end
    endtask : wait_dones

    // Bounded wait for the sequencer to go idle
    task automatic wait_idle;
        int k;
        k = 0;
        do begin
            @(posedge ref_clk);
            #1 k++;
        end while (k < 400 && seq_busy !== 1'b0);
        if (k == 400) begin
            fails++;
            report_and_stop();
        end
    endtask : wait_idle

    // Expected channel of slot i: block channels align down
    function automatic logic [3:0] exp_chan(input logic [2:0] md,
                                            input logic [3:0] fd, input int i);
        if (!md[1]) return fd;
        if (md[0]) return {fd[3], i[2:0]};
        return {fd[3:2], i[1:0]};
    endfunction : exp_chan

    // Read back n slots against channel and marker
    task automatic check_slots(input logic [2:0] md, input logic [3:0] fd,
                               input logic [5:0] t, input int cnt);
        logic [15:0] d;
        for (int i = 0; i < cnt; i++) begin
            rd(4'(OFF_RESULT + i), d);
            check("result_slot", d, {6'h00, t, exp_chan(md, fd, i)});
        end
    endtask : check_slots

    // Main sequence
    initial begin
        ref_clk = 1'b0;
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        slow = 1'b0;
        tag = 6'h00;
        fails = 0;
        checked = 0;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        // Reset values, read-only status, unmapped hole
        rd(OFF_TIMING, v);
        check("timing_control_reg", v, TIMING_RST);
        rd(OFF_CONV, v);
        check("conversion_control_reg", v, {9'h000, CONV_RST});
        rd(OFF_RESULT, v);
        check("result_slot", v, {6'h00, RESULT_RST});
        wr(OFF_TIMING, 16'hA5C3);
        rd(OFF_TIMING, v);
        check("timing_control_reg", v, 16'hA5C3);
        wr(OFF_STATUS, 16'hFFFF);
        rd(OFF_STATUS, v);
        check("converter_status_reg", v, 16'h0000);
        rd(4'h5, v);
        check("unmapped", v, 16'h0000);
        // Every mode, varied fields, fast and slow array
        for (m = 0; m < 8; m++) begin
            f = 4'((m * 5 + 3) % 16);
            n = m[0] ? 8 : 4;
            slow <= m[1];
            tag <= 6'(m + 1);
            wr(OFF_CONV, {9'h000, m[2:0], f});
            if (m < 4) begin
                wait_idle();
                rd(OFF_STATUS, v);
                check("status", v, n == 8 ? 16'h01FF : 16'h010F);
                check_slots(m[2:0], f, tag, n);
            end else begin
                // Poll until first pass ends, still running
                v = 16'h0000;
                for (int k = 0; k < 60 && v[8] !== 1'b1; k++) rd(OFF_STATUS, v);
                if (v[8] !== 1'b1) begin
                    fails++;
                    report_and_stop();
                end
                check("status", v & 16'h81FF,
                      n == 8 ? 16'h81FF : 16'h810F);
                // New marker: one more full pass must overwrite every slot
                tag <= 6'(m + 33);
                wait_dones(9);
                wr(OFF_TIMING, 16'h0003);
                check_slots(m[2:0], f, tag, n);
                rd(OFF_STATUS, v);
                check("status", v & 16'h81FF, 16'h0000);
            end
        end
        // Restart in mid-sequence with new parameters
        slow <= 1'b1;
        tag <= 6'h2A;
        wr(OFF_CONV, 16'h0012);
        wait_dones(3);
        rd(OFF_STATUS, v);
        check("status", v & 16'h81FF, 16'h8007);
        wr(OFF_CONV, 16'h0009);
        rd(OFF_STATUS, v);
        check("status", v & 16'h81FF, 16'h8000);
        wait_idle();
        rd(OFF_STATUS, v);
        check("status", v, 16'h010F);
        check_slots(3'h0, 4'h9, 6'h2A, 4);
        report_and_stop();
    end
endmodule : tb_top
